// [logic/hgw_watchdog.sv]
`timescale 1ns/1ps

// Overview of operation
// - The watchdog holds a 14-bit up-counter and a write-only service key register.
// - After any reset the counter is disabled and does not count until armed.
// - Writing 1Eh then E1h to the service key register (index A6h) arms the counter.
// - While armed the counter advances once per 2^n machine cycles, n being the prescale select (0 after reset).
// - Once armed no software write disarms it; only reset or overflow does.
// - Writing 1Eh then E1h while armed restarts the counter from zero.
// - When the counter reaches 3FFFh it overflows and the watchdog resets itself.
// - On overflow the reset pin is driven high for 96 oscillator periods.
// - The key register reads as zero and the counter value is never exposed.
// - A 2^7 prescaler, selected through the prescale register (A7h), extends timeout.
module hgw_watchdog #(
   parameter int unsigned MC_DIV = hgw_pkg::MC_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   // AXI4-Lite write address
   input  wire logic [hgw_pkg::ADDR_W-1:0]  i_s_axi_awaddr,
   input  wire logic                        i_s_axi_awvalid,
   output logic                             o_s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                 i_s_axi_wdata,
   input  wire logic [3:0]                  i_s_axi_wstrb,
   input  wire logic                        i_s_axi_wvalid,
   output logic                             o_s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                       o_s_axi_bresp,
   output logic                             o_s_axi_bvalid,
   input  wire logic                        i_s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [hgw_pkg::ADDR_W-1:0]  i_s_axi_araddr,
   input  wire logic                        i_s_axi_arvalid,
   output logic                             o_s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                      o_s_axi_rdata,
   output logic [1:0]                       o_s_axi_rresp,
   output logic                             o_s_axi_rvalid,
   input  wire logic                        i_s_axi_rready,
   // Reset pin drive and status
   output logic                             o_rst_pulse,
   output logic                             o_armed
);

   ////////////////////////////////////////////////////////////////////////////////
   // State of the block in one record; the time base in u_tick_gen keeps its own
   typedef struct packed {
      hgw_pkg::hgw_mode_e                   mode;
      hgw_pkg::hgw_key_e                    key;
      logic [hgw_pkg::CNT_W-1:0]            cnt;
      logic [hgw_pkg::PULSE_W-1:0]          pulse;
      logic [hgw_pkg::PRESCALE_SEL_W-1:0]   presc_cfg;
      logic                                 tick_clear;
      logic                                 armed;
      logic                                 rst_out;
      logic                                 aw_held;
      logic                                 w_held;
      logic [hgw_pkg::ADDR_W-1:0]           waddr;
      logic [7:0]                           wdata;
      logic                                 wlane0;
      logic                                 awready;
      logic                                 wready;
      logic                                 bvalid;
      logic [1:0]                           bresp;
      logic                                 arready;
      logic                                 rvalid;
      logic [31:0]                          rdata;
      logic [1:0]                           rresp;
   } hgw_state_s;

   localparam hgw_state_s ST_RESET = '{
      mode:      hgw_pkg::MODE_OFF,
      key:       hgw_pkg::KEY_IDLE,
      presc_cfg: hgw_pkg::PRESCALE_RST,
      awready:   1'b1,
      wready:    1'b1,
      arready:   1'b1,
      bresp:     hgw_pkg::RESP_OKAY,
      rresp:     hgw_pkg::RESP_OKAY,
      default:   '0
   };

   localparam logic [hgw_pkg::PULSE_W-1:0] PULSE_LOAD =
      hgw_pkg::PULSE_W'(hgw_pkg::RST_PULSE_CYC - 1);

   hgw_state_s st;
   hgw_state_s next_st;
   logic       key_write;
   logic       key_done;
   logic       wr_go;

   ////////////////////////////////////////////////////////////////////////////////
   // Time base: machine cycle divider and timeout prescaler
   hgw_tick_if tick ();

   assign tick.clear     = st.tick_clear;
   assign tick.presc_sel = st.presc_cfg;

   hgw_tick_gen #(
      .MC_DIV    (MC_DIV)
   ) u_tick_gen (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tick      (tick.gen)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state of bus slave, key detector and counter
   always_comb begin
      next_st            = st;
      next_st.tick_clear = 1'b0;
      key_write          = 1'b0;
      key_done           = 1'b0;
      wr_go              = st.aw_held && st.w_held && !st.bvalid;

      // Address and data are taken independently, in either order
      if (i_s_axi_awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.waddr   = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && st.wready) begin
         next_st.w_held  = 1'b1;
         next_st.wdata   = i_s_axi_wdata[7:0];
         next_st.wlane0  = i_s_axi_wstrb[0];
      end

      // Register write once both halves are held; lane 0 carries the byte
      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = hgw_pkg::RESP_OKAY;
         case (st.waddr)
            hgw_pkg::SERVICE_KEY_ADDR: begin
               key_write = st.wlane0;
            end
            hgw_pkg::PRESCALE_ADDR: begin
               if (st.wlane0) begin
                  next_st.presc_cfg = st.wdata[hgw_pkg::PRESCALE_SEL_LSB +:
                                               hgw_pkg::PRESCALE_SEL_W];
               end
            end
            hgw_pkg::STATUS_ADDR: begin
               next_st.bresp = hgw_pkg::RESP_OKAY;            // Read-only, write dropped
            end
            default: begin
               next_st.bresp = hgw_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && i_s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready  = !next_st.w_held && !next_st.bvalid;

      // Read channel; the key register and the counter never show up here
      if (i_s_axi_arvalid && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = hgw_pkg::RESP_OKAY;
         next_st.rdata   = 32'h0000_0000;
         case (i_s_axi_araddr)
            hgw_pkg::SERVICE_KEY_ADDR: begin
               next_st.rdata = 32'h0000_0000;
            end
            hgw_pkg::PRESCALE_ADDR: begin
               next_st.rdata[hgw_pkg::PRESCALE_SEL_LSB +:
                             hgw_pkg::PRESCALE_SEL_W] = st.presc_cfg;
            end
            hgw_pkg::STATUS_ADDR: begin
               next_st.rdata[hgw_pkg::STATUS_ARMED_BIT]  = st.armed;
               next_st.rdata[hgw_pkg::STATUS_FIRING_BIT] = st.rst_out;
            end
            default: begin
               next_st.rresp = hgw_pkg::RESP_SLVERR;
            end
         endcase
      end else if (st.rvalid && i_s_axi_rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end

      // Key sequence; writes are ignored while the reset pulse is out
      if (key_write && st.mode != hgw_pkg::MODE_FIRING) begin
         case (st.key)
            hgw_pkg::KEY_IDLE: begin
               if (st.wdata == hgw_pkg::KEY_FIRST) begin
                  next_st.key = hgw_pkg::KEY_HALF;
               end
            end
            hgw_pkg::KEY_HALF: begin
               if (st.wdata == hgw_pkg::KEY_SECOND) begin
                  key_done    = 1'b1;
                  next_st.key = hgw_pkg::KEY_IDLE;
               end else if (st.wdata == hgw_pkg::KEY_FIRST) begin
                  next_st.key = hgw_pkg::KEY_HALF;            // Fresh first key
               end else begin
                  next_st.key = hgw_pkg::KEY_IDLE;
               end
            end
            default: begin
               next_st.key = hgw_pkg::KEY_IDLE;
            end
         endcase
      end

      // Watchdog mode; overflow beats a service write landing in the same cycle
      case (st.mode)
         hgw_pkg::MODE_OFF: begin
            next_st.cnt = '0;
            if (key_done) begin
               next_st.mode       = hgw_pkg::MODE_ARMED;
               next_st.tick_clear = 1'b1;
            end
         end
         hgw_pkg::MODE_ARMED: begin
            // No write path leads back to OFF from here
            if (st.cnt == hgw_pkg::CNT_TERMINAL) begin
               next_st.mode      = hgw_pkg::MODE_FIRING;
               next_st.pulse     = PULSE_LOAD;
               next_st.cnt       = '0;
               next_st.key       = hgw_pkg::KEY_IDLE;
               next_st.presc_cfg = hgw_pkg::PRESCALE_RST;     // Self reset clears config
            end else if (key_done) begin
               next_st.cnt        = '0;
               next_st.tick_clear = 1'b1;
            end else if (tick.cnt_tick) begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         hgw_pkg::MODE_FIRING: begin
            if (st.pulse == '0) begin
               next_st.mode = hgw_pkg::MODE_OFF;
            end else begin
               next_st.pulse = st.pulse - 1'b1;
            end
         end
         default: begin
            next_st.mode = hgw_pkg::MODE_OFF;
         end
      endcase

      // Pin and status outputs follow the mode, registered with it
      next_st.armed   = (next_st.mode == hgw_pkg::MODE_ARMED);
      next_st.rst_out = (next_st.mode == hgw_pkg::MODE_FIRING);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; a hardware reset always lands in the disabled mode
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign o_s_axi_awready = st.awready;
   assign o_s_axi_wready  = st.wready;
   assign o_s_axi_bresp   = st.bresp;
   assign o_s_axi_bvalid  = st.bvalid;
   assign o_s_axi_arready = st.arready;
   assign o_s_axi_rdata   = st.rdata;
   assign o_s_axi_rresp   = st.rresp;
   assign o_s_axi_rvalid  = st.rvalid;
   assign o_rst_pulse     = st.rst_out;
   assign o_armed         = st.armed;

endmodule : hgw_watchdog

// [logic/hgw_pkg.sv]
package hgw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map: printed offsets are word indices, byte address is four times
   localparam logic [7:0]  SERVICE_KEY_IDX   = 8'ha6;
   localparam logic [7:0]  PRESCALE_IDX      = 8'ha7;
   localparam logic [7:0]  STATUS_IDX        = 8'ha8;
   localparam int unsigned ADDR_W            = 12;
   localparam logic [11:0] SERVICE_KEY_ADDR  = {2'h0, SERVICE_KEY_IDX, 2'h0};
   localparam logic [11:0] PRESCALE_ADDR     = {2'h0, PRESCALE_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR       = {2'h0, STATUS_IDX, 2'h0};

   ////////////////////////////////////////////////////////////////////////////////
   // Key values and field layout
   localparam logic [7:0]  KEY_FIRST         = 8'h1e;
   localparam logic [7:0]  KEY_SECOND        = 8'he1;
   localparam int unsigned PRESCALE_SEL_LSB  = 0;
   localparam int unsigned PRESCALE_SEL_W    = 3;
   localparam logic [2:0]  PRESCALE_RST      = 3'h0;
   localparam int unsigned STATUS_ARMED_BIT  = 0;
   localparam int unsigned STATUS_FIRING_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Counter and timing
   localparam int unsigned CNT_W             = 14;
   localparam logic [13:0] CNT_TERMINAL      = 14'h3fff;
   localparam int unsigned PRESC_W           = 7;
   localparam int unsigned MC_DIV_DEFAULT    = 12;
   localparam int unsigned OSC_PERIOD_PS     = 5000;
   localparam int unsigned CLK_PERIOD_PS     = 5000;
   localparam int unsigned RST_PULSE_OSC     = 96;
   localparam int unsigned RST_PULSE_CYC     =
      (RST_PULSE_OSC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PULSE_W           = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus responses and state encodings
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef enum logic {
      KEY_IDLE = 1'b0,
      KEY_HALF = 1'b1
   } hgw_key_e;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_ARMED  = 2'h1,
      MODE_FIRING = 2'h3
   } hgw_mode_e;

endpackage : hgw_pkg

// [logic/hgw_tick_if.sv]
`timescale 1ns/1ps

// Time base handshake between the watchdog core and its tick generator
interface hgw_tick_if;
   logic       clear;
   logic [2:0] presc_sel;
   logic       mc_tick;
   logic       cnt_tick;

   modport gen (
      input  clear,
      input  presc_sel,
      output mc_tick,
      output cnt_tick
   );

   modport core (
      output clear,
      output presc_sel,
      input  mc_tick,
      input  cnt_tick
   );
endinterface : hgw_tick_if

// [logic/hgw_tick_gen.sv]
`timescale 1ns/1ps

module hgw_tick_gen #(
   parameter int unsigned MC_DIV = hgw_pkg::MC_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Time base toward the core
   hgw_tick_if.gen   tick
);

   // A divide by one still needs a one-bit counter, else the cast below has no width
   localparam int unsigned MC_W = (MC_DIV > 1) ? $clog2(MC_DIV) : 1;

   typedef struct packed {
      logic [MC_W-1:0]              mc_cnt;
      logic [hgw_pkg::PRESC_W-1:0]  presc;
      logic                         mc_tick;
      logic                         cnt_tick;
   } hgw_tick_s;

   hgw_tick_s st;
   hgw_tick_s next_st;
   logic [hgw_pkg::PRESC_W-1:0] sel_mask;

   ////////////////////////////////////////////////////////////////////////////////
   // Machine cycle divider, then a 2^n prescaler picked by the select field
   always_comb begin
      next_st          = st;
      next_st.mc_tick  = 1'b0;
      next_st.cnt_tick = 1'b0;
      sel_mask = hgw_pkg::PRESC_W'((8'h01 << tick.presc_sel) - 8'h01);
      if (tick.clear) begin                        // Restart keeps the full timeout
         next_st.mc_cnt = '0;
         next_st.presc  = '0;
      end else if (st.mc_cnt == MC_W'(MC_DIV - 1)) begin
         next_st.mc_cnt  = '0;
         next_st.mc_tick = 1'b1;
         if ((st.presc & sel_mask) == sel_mask) begin
            next_st.cnt_tick = 1'b1;
         end
         next_st.presc = st.presc + 1'b1;
      end else begin
         next_st.mc_cnt = st.mc_cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick.mc_tick  = st.mc_tick;
   assign tick.cnt_tick = st.cnt_tick;

endmodule : hgw_tick_gen

// [test/hgw_watchdog_chk.sv]
`timescale 1ns/1ps

module hgw_watchdog_chk #(
   parameter int unsigned MC_DIV = hgw_pkg::MC_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Register bus handshakes
   input  wire logic        o_s_axi_awready,
   input  wire logic        o_s_axi_wready,
   input  wire logic        o_s_axi_bvalid,
   input  wire logic        i_s_axi_arvalid,
   input  wire logic        o_s_axi_arready,
   input  wire logic [31:0] o_s_axi_rdata,
   input  wire logic        o_s_axi_rvalid,
   // Watchdog outputs
   input  wire logic        o_rst_pulse,
   input  wire logic        o_armed
);

   ////////////////////////////////////////////////////////////////////////////////
   // Length of the current reset pulse; a repetition of 96 would be too slow to unroll
   logic [7:0] high_cnt;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n)
         high_cnt <= 8'h00;
      else if (o_rst_pulse)
         high_cnt <= high_cnt + 8'h01;
      else
         high_cnt <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One clock domain, so clock and disable are given once
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   pulse_len_a: assert property ($fell(o_rst_pulse) |-> high_cnt == 8'h60)
      else $error("reset pulse did not last 96 cycles");
   pulse_bound_a: assert property (o_rst_pulse |-> high_cnt < 8'h60)
      else $error("reset pulse longer than 96 cycles");
   pulse_disarm_a: assert property ($rose(o_rst_pulse) |-> !o_armed && $past(o_armed))
      else $error("overflow pulse without armed counter or without disarm");
   arm_on_write_a: assert property ($rose(o_armed) |-> $rose(o_s_axi_bvalid))
      else $error("armed without a completing key write");
   armed_hold_a: assert property ($fell(o_armed) |-> o_rst_pulse)
      else $error("watchdog disarmed without overflow or reset");
   read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
      |=> o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read not answered one cycle after address");
   write_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write accepted while response pending");
   narrow_read_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
      else $error("read data wider than the register set");

endmodule : hgw_watchdog_chk

bind hgw_watchdog hgw_watchdog_chk #(.MC_DIV(MC_DIV)) u_chk (
   .i_ref_clk       (i_ref_clk),
   .i_rst_n         (i_rst_n),
   .o_s_axi_awready (o_s_axi_awready),
   .o_s_axi_wready  (o_s_axi_wready),
   .o_s_axi_bvalid  (o_s_axi_bvalid),
   .i_s_axi_arvalid (i_s_axi_arvalid),
   .o_s_axi_arready (o_s_axi_arready),
   .o_s_axi_rdata   (o_s_axi_rdata),
   .o_s_axi_rvalid  (o_s_axi_rvalid),
   .o_rst_pulse     (o_rst_pulse),
   .o_armed         (o_armed)
);

// [test/test_keyed_hardware_watchdog.sv]
`timescale 1ns/1ps

module test_keyed_hardware_watchdog;

   ////////////////////////////////////////////////////////////////////////////////
   // Short names for the map; upper byte address is unmapped
   localparam logic [11:0] KA  = hgw_pkg::SERVICE_KEY_ADDR;
   localparam logic [11:0] PA  = hgw_pkg::PRESCALE_ADDR;
   localparam logic [11:0] SA  = hgw_pkg::STATUS_ADDR;
   localparam logic [11:0] BAD = 12'h2a4;
   localparam logic [7:0]  F   = hgw_pkg::KEY_FIRST;
   localparam logic [7:0]  S   = hgw_pkg::KEY_SECOND;
   localparam logic [1:0]  OK  = hgw_pkg::RESP_OKAY;
   localparam logic [1:0]  ER  = hgw_pkg::RESP_SLVERR;
   localparam int          CT  = int'(hgw_pkg::CNT_TERMINAL);

   typedef struct {logic wr; logic [11:0] a; logic [7:0] d; logic [31:0] ed; logic [1:0] er;}
      hgw_row_s;

   logic        i_ref_clk;
   logic        i_rst_n;
   logic [11:0] i_s_axi_awaddr;
   logic        i_s_axi_awvalid;
   logic        o_s_axi_awready;
   logic [31:0] i_s_axi_wdata;
   logic [3:0]  i_s_axi_wstrb;
   logic        i_s_axi_wvalid;
   logic        o_s_axi_wready;
   logic [1:0]  o_s_axi_bresp;
   logic        o_s_axi_bvalid;
   logic        i_s_axi_bready;
   logic [11:0] i_s_axi_araddr;
   logic        i_s_axi_arvalid;
   logic        o_s_axi_arready;
   logic [31:0] o_s_axi_rdata;
   logic [1:0]  o_s_axi_rresp;
   logic        o_s_axi_rvalid;
   logic        i_s_axi_rready;
   logic        o_rst_pulse;
   logic        o_armed;
   int          err_count;
   int          total_checks;
   int          pulse_cnt;
   int          n;
   logic [1:0]  resp;
   logic [31:0] rd;

   // Ordinary register cases; the key rows cover bad orders before the good one
   hgw_row_s rows [18] = '{
      '{0, SA, 0, 0, OK}, '{0, PA, 0, 0, OK}, '{1, PA, 8'h05, 0, OK}, '{0, PA, 0, 32'h5, OK},
      '{1, PA, 8'h00, 0, OK}, '{0, KA, 0, 0, OK}, '{1, BAD, 0, 0, ER}, '{0, BAD, 0, 0, ER},
      '{1, KA, S, 0, OK}, '{0, SA, 0, 0, OK}, '{1, KA, F, 0, OK}, '{1, KA, 8'h55, 0, OK},
      '{1, KA, S, 0, OK}, '{0, SA, 0, 0, OK}, '{1, KA, F, 0, OK}, '{1, KA, F, 0, OK},
      '{1, KA, S, 0, OK}, '{0, SA, 0, 32'h1, OK}};

   // Slow machine cycle shortened to one clock to keep the run short
   hgw_watchdog #(.MC_DIV(1)) dut (.i_ref_clk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid,
      .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
      .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
      .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
      .o_rst_pulse, .o_armed);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 200 MHz
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   // Cycles spent with the reset pin driven
   always @(posedge i_ref_clk) begin
      if (o_rst_pulse === 1'b1)
         pulse_cnt <= pulse_cnt + 1;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Address and data offered together, each dropped once its ready was seen
   task wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge i_ref_clk);
      i_s_axi_awaddr  <= a;
      i_s_axi_wdata   <= {24'h000000, d};
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid  <= 1'b1;
      i_s_axi_bready  <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      end while (o_s_axi_bvalid !== 1'b1);
      r = o_s_axi_bresp;
      i_s_axi_bready <= 1'b0;
   endtask : wr

   task rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_ref_clk);
      i_s_axi_araddr  <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready  <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (o_s_axi_rvalid !== 1'b1);
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      i_s_axi_rready <= 1'b0;
   endtask : rdr

   task svc;
      wr(KA, F, resp);
      wr(KA, S, resp);
   endtask : svc

   task complete_run;
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog of the bench, set beyond the roughly 85k cycles of the tests
   initial begin
      repeat (100000) @(posedge i_ref_clk);
      err_count++;
      $display("Error at %0t: run timed out", $time);
      complete_run;
   end

   // Main sequence
   initial begin
      {i_s_axi_awaddr, i_s_axi_awvalid, i_s_axi_wdata, i_s_axi_wvalid} = '0;
      {i_s_axi_bready, i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} = '0;
      i_s_axi_wstrb = 4'h1;
      i_rst_n       = 1'b0;
      {err_count, total_checks, pulse_cnt} = '0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(posedge i_ref_clk);
      check(32'(o_armed), 32'h0);
      for (int i = 0; i < 18; i++) begin
         rd = 32'h0;
         if (rows[i].wr)
            wr(rows[i].a, rows[i].d, resp);
         else
            rdr(rows[i].a, rd, resp);
         check(rd, rows[i].wr ? 32'h0 : rows[i].ed);
         check(32'(resp), 32'(rows[i].er));
      end
      // Lane 0 off leaves the prescale alone; a status write is dropped and keeps it armed
      i_s_axi_wstrb <= 4'h0;
      wr(PA, 8'h07, resp);
      i_s_axi_wstrb <= 4'h1;
      rdr(PA, rd, resp);
      check(rd, 32'h0);
      wr(SA, 8'h00, resp);
      check(32'(resp), 32'(OK));
      rdr(SA, rd, resp);
      check(rd, 32'h1);
      $display("Register table test done");
      // Services well inside the timeout; sel 1 outlives the unscaled timeout
      repeat (2) begin
         repeat (12000) @(posedge i_ref_clk);
         svc;
      end
      wr(PA, 8'h01, resp);
      svc;
      repeat (24000) @(posedge i_ref_clk);
      check(32'(pulse_cnt), 32'h0);
      check(32'(o_armed), 32'h1);
      $display("Service test done");
      // Overflow after a restart from zero at one count per cycle
      wr(PA, 8'h00, resp);
      svc;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_rst_pulse !== 1'b1);
      check(32'(n >= CT - 4 && n <= CT + 8), 32'h1);
      n = 0;
      while (o_rst_pulse === 1'b1) begin
         n++;
         @(posedge i_ref_clk);
      end
      check(32'(n), 32'(hgw_pkg::RST_PULSE_OSC));
      check(32'(o_armed), 32'h0);
      rdr(PA, rd, resp);
      check(rd, 32'h0);
      $display("Overflow test done");
      // Reset in mid-run disarms, and nothing counts afterwards
      svc;
      check(32'(o_armed), 32'h1);
      repeat (100) @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(posedge i_ref_clk);
      check(32'(o_armed), 32'h0);
      n = pulse_cnt;
      repeat (20000) @(posedge i_ref_clk);
      check(32'(pulse_cnt), 32'(n));
      $display("Reset test done");
      complete_run;
   end

endmodule : test_keyed_hardware_watchdog
